// *** dsl_top.sv ***
`include "dsl_regs.svh"

module dsl_top #(
    parameter int unsigned WDT_CYCLES = `DSL_WDT_CYCLES
) (
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic                       sclk,
    input  wire logic                       frame_sel_n,
    input  wire logic                       serial_in,
    output logic                            serial_out,
    input  wire logic                       load_outputs_n,
    input  wire logic                       clear_in,
    input  wire logic                       board_addr_bit0,
    input  wire logic                       board_addr_bit1,
    input  wire logic                       pec_enable,
    input  wire logic                       open_circuit,
    input  wire logic                       short_circuit,
    input  wire logic                       over_temp,
    output dsl_pkg::dsl_code_t [3:0]        dac_out,
    output logic                            alert,
    output logic                            fault_o,
    output logic                            fault_oe_n
);

    // Serial clock domain.
    // The frame select belongs to the link itself, so the link logic reads it directly.
    // The core only reads this state once its synchronised select shows the frame is over.

    logic        [31:0] shreg_q;
    logic        [5:0]  bitcnt_q;
    logic               fresh_q;
    logic               out_bit_q;
    dsl_pkg::dsl_frame_s rb_q;

    // Marks that no falling edge has been seen since the select rose.
    always_ff @(negedge sclk or negedge resetn or posedge frame_sel_n) begin
        if (!resetn) begin
            fresh_q <= 1'b1;
        end else if (frame_sel_n) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    always_ff @(negedge sclk or negedge resetn) begin
        if (!resetn) begin
            shreg_q <= 32'h0000_0000;
        end else if (!frame_sel_n) begin
            shreg_q <= {shreg_q[30:0], serial_in};
        end
    end

    // Count is kept after the frame so the core clock can judge length.
    always_ff @(negedge sclk or negedge resetn) begin
        if (!resetn) begin
            bitcnt_q <= 6'h00;
        end else if (!frame_sel_n) begin
            if (fresh_q) begin
                bitcnt_q <= 6'h01;
            end else if (bitcnt_q != 6'h3F) begin
                bitcnt_q <= bitcnt_q + 6'h01;
            end
        end
    end

    always_ff @(posedge sclk or negedge resetn) begin
        if (!resetn) begin
            out_bit_q <= 1'b0;
        end else if (!frame_sel_n) begin
            if (bitcnt_q < `DSL_FRAME_BITS) begin
                out_bit_q <= rb_q[5'd23 - bitcnt_q[4:0]];
            end else begin
                out_bit_q <= 1'b0;
            end
        end
    end

    // The first bit is shown before any clock edge of the frame.
    assign serial_out = frame_sel_n ? 1'b0 : (fresh_q ? rb_q[23] : out_bit_q);

    // Core clock domain.

    dsl_pkg::dsl_pins_s pins_in;
    dsl_pkg::dsl_pins_s meta_q;
    dsl_pkg::dsl_pins_s sync_q;
    logic               sel_prev_q;
    logic               load_prev_q;
    logic               clr_prev_q;

    assign pins_in.sel_n   = frame_sel_n;
    assign pins_in.load_n  = load_outputs_n;
    assign pins_in.clear   = clear_in;
    assign pins_in.ad1     = board_addr_bit1;
    assign pins_in.ad0     = board_addr_bit0;
    assign pins_in.pec_en  = pec_enable;
    assign pins_in.open_c  = open_circuit;
    assign pins_in.short_c = short_circuit;
    assign pins_in.hot     = over_temp;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= `DSL_PINS_IDLE;
            sync_q <= `DSL_PINS_IDLE;
        end else begin
            meta_q <= pins_in;
            sync_q <= meta_q;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sel_prev_q  <= 1'b1;
            load_prev_q <= 1'b1;
            clr_prev_q  <= 1'b0;
        end else begin
            sel_prev_q  <= sync_q.sel_n;
            load_prev_q <= sync_q.load_n;
            clr_prev_q  <= sync_q.clear;
        end
    end

    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        logic       fb;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) begin
            fb = c[7] ^ d[i];
            c = {c[6:0], 1'b0};
            if (fb) begin
                c = c ^ `DSL_CRC_POLY;
            end
        end
        return c;
    endfunction

    logic                frame_end;
    logic                frame_start;
    logic                load_fall;
    logic                clr_rise;
    dsl_pkg::dsl_frame_s word;
    logic                len_ok;
    logic                crc_ok;
    logic                addr_ok;
    logic                accept;
    logic                pec_fail;
    logic                wr_data;
    logic                wr_ctrl;
    logic                rd_req;

    // The shift register is idle once the synchronised select is high.
    assign frame_end   = sync_q.sel_n & ~sel_prev_q;
    assign frame_start = ~sync_q.sel_n & sel_prev_q;
    assign load_fall   = ~sync_q.load_n & load_prev_q;
    assign clr_rise    = sync_q.clear & ~clr_prev_q;

    assign word   = sync_q.pec_en ? shreg_q[31:8] : shreg_q[23:0];
    assign len_ok = bitcnt_q == (sync_q.pec_en ? `DSL_PEC_FRAME_BITS : `DSL_FRAME_BITS);
    assign crc_ok = ~sync_q.pec_en | (crc8(word) == shreg_q[7:0]);
    assign addr_ok = word.board == {sync_q.ad1, sync_q.ad0};

    assign accept   = frame_end & len_ok & crc_ok & addr_ok;
    assign pec_fail = frame_end & len_ok & ~crc_ok;
    assign wr_data  = accept & ~word.rd & ~word.ctrl;
    assign wr_ctrl  = accept & ~word.rd & word.ctrl;
    assign rd_req   = accept & word.rd;

    dsl_pkg::dsl_code_t [3:0] in_q;
    dsl_pkg::dsl_code_t [3:0] out_q;
    logic               [3:0] pend_q;
    logic               [3:0] clr_en_q;
    logic               [3:0] clr_hi_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            in_q <= {4{`DSL_OUT_RST}};
        end else if (wr_data) begin
            in_q[word.chan] <= word.data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clr_en_q <= 4'h0;
            clr_hi_q <= 4'h0;
        end else if (wr_ctrl) begin
            clr_en_q[word.chan] <= word.data[0];
            clr_hi_q[word.chan] <= word.data[1];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend_q <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_data && sync_q.load_n && word.chan == i[1:0]) begin
                    pend_q[i] <= 1'b1;
                end else if (load_fall && !sync_q.clear) begin
                    pend_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_q <= {4{`DSL_OUT_RST}};
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (clr_rise && clr_en_q[i]) begin
                    out_q[i] <= clr_hi_q[i] ? `DSL_CLR_CODE_HI : `DSL_CLR_CODE_LO;
                end else if (!sync_q.clear) begin
                    if (wr_data && !sync_q.load_n && word.chan == i[1:0]) begin
                        out_q[i] <= word.data;
                    end else if (load_fall && pend_q[i]) begin
                        out_q[i] <= in_q[i];
                    end
                end
            end
        end
    end

    assign dac_out = out_q;

    // The readback word only changes while no frame is in progress.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rb_q <= 24'h00_0000;
        end else if (rd_req) begin
            rb_q.rd    <= 1'b1;
            rb_q.board <= word.board;
            rb_q.chan  <= word.chan;
            rb_q.ctrl  <= word.ctrl;
            rb_q.rsvd  <= 2'b00;
            if (word.ctrl) begin
                rb_q.data <= {14'h0000, clr_hi_q[word.chan], clr_en_q[word.chan]};
            end else begin
                rb_q.data <= out_q[word.chan];
            end
        end
    end

    logic [31:0] wdt_q;
    logic        alert_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wdt_q   <= 32'h0000_0000;
            alert_q <= 1'b0;
        end else if (frame_start || frame_end) begin
            wdt_q   <= 32'h0000_0000;
            alert_q <= 1'b0;
        end else if (wdt_q >= WDT_CYCLES - 32'd1) begin
            alert_q <= 1'b1;
        end else begin
            wdt_q <= wdt_q + 32'h0000_0001;
        end
    end

    assign alert = alert_q;

    logic pec_err_q;
    logic fault_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pec_err_q <= 1'b0;
        end else if (pec_fail) begin
            pec_err_q <= 1'b1;
        end else if (accept) begin
            pec_err_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= sync_q.open_c | sync_q.short_c | sync_q.hot | pec_err_q;
        end
    end

    assign fault_o    = 1'b0;
    assign fault_oe_n = ~fault_q;

endmodule // dsl_top

// *** dsl_regs.svh ***
`ifndef DSL_REGS_SVH
`define DSL_REGS_SVH
`define DSL_FRAME_BITS 6'd24
`define DSL_PEC_FRAME_BITS 6'd32
`define DSL_CRC_POLY 8'h07
`define DSL_CLR_CODE_HI 16'hFFFF
`define DSL_CLR_CODE_LO 16'h0000
`define DSL_OUT_RST 16'h0000
`define DSL_PINS_IDLE 9'h180
`define DSL_SCLK_MAX_MHZ 30
`define DSL_CLK_HZ 10000000
`define DSL_WDT_MS 1000
`define DSL_WDT_CYCLES (`DSL_WDT_MS * (`DSL_CLK_HZ / 1000))
`endif

// *** dsl_pkg.sv ***
package dsl_pkg;
    typedef logic [15:0] dsl_code_t;

    typedef struct packed {
        logic       rd;
        logic [1:0] board;
        logic [1:0] chan;
        logic       ctrl;
        logic [1:0] rsvd;
        dsl_code_t  data;
    } dsl_frame_s;

    typedef struct packed {
        logic sel_n;
        logic load_n;
        logic clear;
        logic ad1;
        logic ad0;
        logic pec_en;
        logic open_c;
        logic short_c;
        logic hot;
    } dsl_pins_s;
endpackage

// *** dsl_checker.sv ***
`include "dsl_regs.svh"

module dsl_checker #(
    parameter int unsigned WDT_CYCLES = 200
) (
    input wire logic                     clk,
    input wire logic                     resetn,
    input wire logic                     frame_sel_n,
    input wire logic                     serial_out,
    input wire logic                     load_outputs_n,
    input wire logic                     clear_in,
    input wire logic                     pec_enable,
    input wire logic                     open_circuit,
    input wire logic                     short_circuit,
    input wire logic                     over_temp,
    input wire dsl_pkg::dsl_code_t [3:0] dac_out,
    input wire logic                     alert,
    input wire logic                     fault_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // Cycles since the select line last moved.
    logic [31:0] idle_q;
    logic        sel_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idle_q <= 32'h0;
            sel_q  <= 1'b1;
        end else begin
            sel_q  <= frame_sel_n;
            idle_q <= (frame_sel_n != sel_q) ? 32'h0 : idle_q + 32'h1;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence s_quiet6;
        (!frame_sel_n && load_outputs_n && $stable(clear_in))[*6];
    endsequence
    sequence s_no_fault5;
        (!over_temp && !open_circuit && !short_circuit && !pec_enable)[*5];
    endsequence
    property p_sdo_idle;
        frame_sel_n |-> serial_out == 1'b0;
    endproperty
    a_sdo_idle: assert property (p_sdo_idle)
        else $error("serial_out active while deselected");
    property p_hold;
        s_quiet6 |=> $stable(dac_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("output changed with load high");
    property p_clr_block;
        clear_in[*8] |=> $stable(dac_out);
    endproperty
    a_clr_block: assert property (p_clr_block)
        else $error("output written while clear high");
    property p_clr_code(int i);
        $rose(clear_in) |-> ##6 (dac_out[i] == $past(dac_out[i], 6)
            || dac_out[i] == `DSL_CLR_CODE_HI || dac_out[i] == `DSL_CLR_CODE_LO);
    endproperty
    for (genvar i = 0; i < 4; i++) begin : g_clr
        a_clr_code: assert property (p_clr_code(i))
            else $error("clear gave a foreign code");
    end
    property p_fault_pull;
        over_temp[*4] |=> !fault_oe_n;
    endproperty
    a_fault_pull: assert property (p_fault_pull)
        else $error("fault pin not pulled");
    property p_fault_rel;
        s_no_fault5 |=> fault_oe_n;
    endproperty
    a_fault_rel: assert property (p_fault_rel)
        else $error("fault pin pulled without cause");
    property p_alert_clr;
        $fell(frame_sel_n) |-> ##4 !alert;
    endproperty
    a_alert_clr: assert property (p_alert_clr)
        else $error("alert kept after activity");
    property p_alert_early;
        $rose(alert) |-> idle_q >= WDT_CYCLES - 2;
    endproperty
    a_alert_early: assert property (p_alert_early)
        else $error("alert raised too early");
    property p_alert_late;
        idle_q == WDT_CYCLES + 8 |-> alert;
    endproperty
    a_alert_late: assert property (p_alert_late)
        else $error("alert missing after idle time");
    property p_reset;
        disable iff (1'b0) !resetn |-> dac_out == '0 && !alert && fault_oe_n;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs not reset");
endmodule // dsl_checker

bind dsl_top dsl_checker #(.WDT_CYCLES(WDT_CYCLES)) u_chk (.clk, .resetn, .frame_sel_n,
    .serial_out, .load_outputs_n, .clear_in, .pec_enable, .open_circuit, .short_circuit,
    .over_temp, .dac_out, .alert, .fault_oe_n);

// *** dsl_host_model.sv ***
module dsl_host_model (
    input  wire logic clk,
    output logic      sclk,
    output logic      frame_sel_n,
    output logic      serial_in,
    input  wire logic serial_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sclk = 1'b1;
        frame_sel_n = 1'b1;
        serial_in = 1'b0;
    end
    task automatic shift_frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
        // Starting just after a core edge keeps every pin change off the core clock edges.
        @(posedge clk);
        #7;
        frame_sel_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = tx[i];
            #40;
            rx[i] = serial_out;
            sclk = 1'b0;
            #40;
            sclk = 1'b1;
        end
        #40;
        frame_sel_n = 1'b1;
        serial_in = ~serial_in;
        // The select stays high long enough for the core to finish with the frame.
        #500;
        @(negedge clk);
    endtask
    task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
        logic [31:0] r;
        shift_frame({8'h00, tx}, 24, r);
        rx = r[23:0];
    endtask
    task automatic xfer32(input logic [31:0] tx);
        logic [31:0] r;
        shift_frame(tx, 32, r);
    endtask
endmodule // dsl_host_model

// *** dac_serial_load_clear_tb.sv ***
module dac_serial_load_clear_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned WDT = 200;
    localparam logic [1:0]  BRD = 2'h2;
    logic clk, resetn, load_outputs_n, clear_in, over_temp;
    logic open_circuit, short_circuit, pec_enable;
    logic sclk, frame_sel_n, serial_in, serial_out, alert, fault_o, fault_oe_n;
    dsl_pkg::dsl_code_t [3:0] dac_out;
    logic [23:0] rx;
    int err_total, checks_done;
    dsl_top #(.WDT_CYCLES(WDT)) u_dut (.clk, .resetn, .sclk, .frame_sel_n, .serial_in,
        .serial_out, .load_outputs_n, .clear_in, .board_addr_bit0(BRD[0]),
        .board_addr_bit1(BRD[1]), .pec_enable, .open_circuit,
        .short_circuit, .over_temp, .dac_out, .alert, .fault_o, .fault_oe_n);
    dsl_host_model u_host (.clk, .sclk, .frame_sel_n, .serial_in, .serial_out);
    always #50 clk = ~clk;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic clks(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [1:0] ch, input logic ctl, input logic [15:0] d,
                      input logic [1:0] brd = BRD);
        u_host.xfer({1'b0, brd, ch, ctl, 2'b00, d}, rx);
    endtask
    task automatic t_direct();
        wr(2'd1, 1'b0, 16'h1234);
        wr(2'd2, 1'b0, 16'hBEEF, ~BRD);
        clks(6);
        cmp(dac_out[1], 16'h1234);
        cmp(dac_out[2], 16'h0000);
        u_host.xfer({1'b1, BRD, 2'd1, 1'b0, 2'b00, 16'h0000}, rx);
        u_host.xfer({1'b0, ~BRD, 21'h0}, rx);
        cmp(rx, {1'b1, BRD, 2'd1, 1'b0, 2'b00, 16'h1234});
    endtask
    task automatic t_load();
        @(posedge clk) load_outputs_n <= 1'b1;
        wr(2'd0, 1'b0, 16'hAAAA);
        wr(2'd3, 1'b0, 16'h5555);
        clks(6);
        cmp({dac_out[0], dac_out[3]}, 32'h0000_0000);
        @(posedge clk) load_outputs_n <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk) cmp(dac_out[0] == 16'hAAAA, dac_out[3] == 16'h5555);
        end
        cmp(dac_out[0] & dac_out[3], 16'h0000);
        cmp(dac_out[0] | dac_out[3], 16'hFFFF);
        cmp(dac_out[0], 16'hAAAA);
        cmp(dac_out[3], 16'h5555);
    endtask
    task automatic t_clear();
        wr(2'd2, 1'b1, 16'h0003);
        wr(2'd3, 1'b1, 16'h0001);
        wr(2'd1, 1'b1, 16'h0000);
        @(posedge clk) clear_in <= 1'b1;
        clks(8);
        cmp(dac_out[2], 16'hFFFF);
        cmp(dac_out[3], 16'h0000);
        cmp(dac_out[1], 16'h1234);
        wr(2'd1, 1'b0, 16'h7777);
        @(posedge clk) load_outputs_n <= 1'b1;
        wr(2'd0, 1'b0, 16'h4444);
        @(posedge clk) load_outputs_n <= 1'b0;
        clks(8);
        cmp(dac_out[1], 16'h1234);
        cmp(dac_out[0], 16'hAAAA);
        @(posedge clk) clear_in <= 1'b0;
    endtask
    task automatic t_status();
        @(posedge clk) over_temp <= 1'b1;
        clks(6);
        cmp({fault_o, fault_oe_n}, 2'b00);
        over_temp <= 1'b0;
        clks(6);
        cmp(fault_oe_n, 1'b1);
        open_circuit <= 1'b1;
        clks(6);
        cmp(fault_oe_n, 1'b0);
        open_circuit  <= 1'b0;
        short_circuit <= 1'b1;
        clks(6);
        cmp(fault_oe_n, 1'b0);
        short_circuit <= 1'b0;
        pec_enable    <= 1'b1;
        u_host.xfer32(32'h4000_0087);
        cmp(fault_oe_n, 1'b0);
        u_host.xfer32(32'h4000_0086);
        cmp(fault_oe_n, 1'b1);
        cmp(dac_out[0], 16'h0000);
        @(posedge clk) pec_enable <= 1'b0;
        clks(WDT + 20);
        cmp(alert, 1'b1);
        wr(2'd0, 1'b0, 16'h0000, ~BRD);
        cmp(alert, 1'b0);
        @(posedge clk) resetn <= 1'b0;
        clks(3);
        cmp({alert, fault_oe_n, |dac_out}, 3'b010);
        resetn <= 1'b1;
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        err_total++;
        end_sim();
    end
    initial begin
        clk = 1'b0;
        resetn <= 1'b0;
        load_outputs_n <= 1'b0;
        clear_in <= 1'b0;
        over_temp <= 1'b0;
        open_circuit <= 1'b0;
        short_circuit <= 1'b0;
        pec_enable <= 1'b0;
        clks(6);
        resetn <= 1'b1;
        clks(2);
        t_direct();
        t_load();
        t_clear();
        t_status();
        end_sim();
    end
endmodule // dac_serial_load_clear_tb
